// >>> src/ssm_pkg.sv
// Package for the spread-spectrum divider modulator: map, fields, resets
`default_nettype none
package ssm_pkg;

    localparam logic [7:0] OFS_SPREAD_ENABLE_PERIOD_HIGH = 8'h10;
    localparam logic [7:0] OFS_SPREAD_PERIOD_LOW         = 8'h11;
    localparam logic [7:0] OFS_DIVIDER_INTEGER           = 8'h12;
    localparam logic [7:0] OFS_DIVIDER_FRACTION_HIGH     = 8'h13;
    localparam logic [7:0] OFS_DIVIDER_FRACTION_LOW      = 8'h14;
    localparam logic [7:0] OFS_SPREAD_STEP_HIGH          = 8'h15;
    localparam logic [7:0] OFS_SPREAD_STEP_LOW           = 8'h16;
    localparam logic [7:0] OFS_DIVIDER_CONTROL           = 8'h18;

    localparam int POS_SPREAD_ENABLE = 7;
    localparam int POS_PERIOD_HIGH   = 0;
    localparam int POS_DIVIDER_RUN_N = 7;

    localparam logic [7:0] RST_SPREAD_ENABLE_PERIOD_HIGH = 8'h00;
    localparam logic [7:0] RST_SPREAD_PERIOD_LOW         = 8'h00;
    localparam logic [7:0] RST_DIVIDER_INTEGER           = 8'h0c;
    localparam logic [7:0] RST_DIVIDER_FRACTION_HIGH     = 8'h80;
    localparam logic [7:0] RST_DIVIDER_FRACTION_LOW      = 8'h00;
    localparam logic [7:0] RST_SPREAD_STEP_HIGH          = 8'h00;
    localparam logic [7:0] RST_SPREAD_STEP_LOW           = 8'h00;
    localparam logic [7:0] RST_DIVIDER_CONTROL           = 8'h80;

    // Step carries 2^24 scaling, divider fraction 2^16
    localparam int STEP_FRAC_BITS = 24;
    localparam int DIV_FRAC_BITS  = 16;

    typedef struct packed {
        logic        spread_enable;
        logic [11:0] half_period;
        logic [15:0] step;
        logic [7:0]  divider_integer_part;
        logic [15:0] divider_fraction_part;
        logic        divider_run_n;
    } ssm_cfg_t;

    typedef enum logic [1:0] {
        SSM_IDLE = 2'b00,
        SSM_DOWN = 2'b01,
        SSM_UP   = 2'b11
    } ssm_state_t;

endpackage
`default_nettype wire

// >>> src/ssm_regs.sv
// Byte-wide configuration register file for the modulator
`timescale 1ns/1ps
`default_nettype none
module ssm_regs
    import ssm_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Byte access port
    input  wire logic       wr_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    // Decoded settings
    output ssm_cfg_t        cfg
);
    logic [7:0] r10_ff, r11_ff, r12_ff, r13_ff, r14_ff, r15_ff, r16_ff;
    logic [7:0] r18_ff;
    logic [7:0] nxt_r10, nxt_r11, nxt_r12, nxt_r13, nxt_r14, nxt_r15;
    logic [7:0] nxt_r16, nxt_r18;

    always_comb begin
        nxt_r10 = r10_ff;
        nxt_r11 = r11_ff;
        nxt_r12 = r12_ff;
        nxt_r13 = r13_ff;
        nxt_r14 = r14_ff;
        nxt_r15 = r15_ff;
        nxt_r16 = r16_ff;
        nxt_r18 = r18_ff;
        if (wr_en) begin
            case (addr)
                // Reserved bits 6..4 hold zero
                OFS_SPREAD_ENABLE_PERIOD_HIGH: nxt_r10 = wdata & 8'h8f;
                OFS_SPREAD_PERIOD_LOW:         nxt_r11 = wdata;
                OFS_DIVIDER_INTEGER:           nxt_r12 = wdata;
                OFS_DIVIDER_FRACTION_HIGH:     nxt_r13 = wdata;
                OFS_DIVIDER_FRACTION_LOW:      nxt_r14 = wdata;
                OFS_SPREAD_STEP_HIGH:          nxt_r15 = wdata;
                OFS_SPREAD_STEP_LOW:           nxt_r16 = wdata;
                OFS_DIVIDER_CONTROL:           nxt_r18 = wdata & 8'h80;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            r10_ff <= RST_SPREAD_ENABLE_PERIOD_HIGH;
            r11_ff <= RST_SPREAD_PERIOD_LOW;
            r12_ff <= RST_DIVIDER_INTEGER;
            r13_ff <= RST_DIVIDER_FRACTION_HIGH;
            r14_ff <= RST_DIVIDER_FRACTION_LOW;
            r15_ff <= RST_SPREAD_STEP_HIGH;
            r16_ff <= RST_SPREAD_STEP_LOW;
            r18_ff <= RST_DIVIDER_CONTROL;
        end else begin
            r10_ff <= nxt_r10;
            r11_ff <= nxt_r11;
            r12_ff <= nxt_r12;
            r13_ff <= nxt_r13;
            r14_ff <= nxt_r14;
            r15_ff <= nxt_r15;
            r16_ff <= nxt_r16;
            r18_ff <= nxt_r18;
        end
    end

    always_comb begin
        case (addr)
            OFS_SPREAD_ENABLE_PERIOD_HIGH: rdata = r10_ff;
            OFS_SPREAD_PERIOD_LOW:         rdata = r11_ff;
            OFS_DIVIDER_INTEGER:           rdata = r12_ff;
            OFS_DIVIDER_FRACTION_HIGH:     rdata = r13_ff;
            OFS_DIVIDER_FRACTION_LOW:      rdata = r14_ff;
            OFS_SPREAD_STEP_HIGH:          rdata = r15_ff;
            OFS_SPREAD_STEP_LOW:           rdata = r16_ff;
            OFS_DIVIDER_CONTROL:           rdata = r18_ff;
            default:                       rdata = 8'h00;
        endcase
    end

    assign cfg.spread_enable = r10_ff[POS_SPREAD_ENABLE];
    assign cfg.half_period   = {r10_ff[POS_PERIOD_HIGH +: 4], r11_ff};
    assign cfg.divider_integer_part  = r12_ff;
    assign cfg.divider_fraction_part = {r13_ff, r14_ff};
    assign cfg.step          = {r15_ff, r16_ff};
    assign cfg.divider_run_n = r18_ff[POS_DIVIDER_RUN_N];
endmodule
`default_nettype wire

// >>> src/ssm_top.sv
// Triangle spread-spectrum modulator for the fractional feedback divider
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Modulate only while spread enable set
// - Disabled: period and step ignored
// - Integer part from byte 0x12
// - Fraction high 0x13, low 0x14
// - Half period: 0x10[3:0] and 0x11
// - Time counted in divider output cycles
// - Step high 0x15, low 0x16
// - Step is increment scaled by 2^24
// - Ramp down from top, back up, never above
// - Rise lasts half-period time steps
// - One time step per modulator clock
// - Divider held in reset while bit low
module ssm_top
    import ssm_pkg::*;
#(
    parameter int PERIOD_W = 12,
    parameter int ACC_W    = 40
)
(
    // Clock (divider output rate) and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // Configuration byte port
    input  wire logic        WR_EN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    output logic      [7:0]  RDATA,
    // Modulated divider value: 8.16 fixed point
    output logic      [23:0] DIV_VALUE,
    output logic             DIV_RESET
);
    // Period times step needs PERIOD_W + 16 bits before the scaling shift
    localparam int MIN_ACC_W = PERIOD_W + 16 + STEP_FRAC_BITS - DIV_FRAC_BITS;

    if (PERIOD_W != 12 || ACC_W < MIN_ACC_W) begin : g_param_check
        $error("ssm_top: unsupported parameters");
    end

    ssm_cfg_t cfg;

    ssm_regs u_ssm_regs (
        .clock (CLOCK),
        .rstn  (RSTN),
        .wr_en (WR_EN),
        .addr  (ADDR),
        .wdata (WDATA),
        .rdata (RDATA),
        .cfg   (cfg)
    );

    ssm_state_t          state_ff,  nxt_state;
    logic [PERIOD_W-1:0] tick_ff,   nxt_tick;
    logic [ACC_W-1:0]    offset_ff, nxt_offset;
    logic [23:0]         div_ff,    nxt_div;
    logic [23:0]         top;
    logic [23:0]         off_div;
    logic                expire;

    // Offset kept with 2^24 scaling; drop 8 bits to reach 2^16 fraction
    function automatic logic [23:0] to_div(input logic [ACC_W-1:0] acc);
        to_div = acc[STEP_FRAC_BITS - DIV_FRAC_BITS +: 24];
    endfunction

    assign top     = {cfg.divider_integer_part, cfg.divider_fraction_part};
    assign off_div = to_div(offset_ff);
    // Expire after half_period steps; zero period treated as one step
    assign expire  = (tick_ff + 1'b1 >= cfg.half_period);

    always_comb begin
        nxt_state  = state_ff;
        nxt_tick   = tick_ff;
        nxt_offset = offset_ff;
        if (!cfg.divider_run_n) begin
            nxt_state  = SSM_IDLE;
            nxt_tick   = '0;
            nxt_offset = '0;
        end else begin
            case (state_ff)
                SSM_IDLE: begin
                    // Period and step untouched while disabled
                    nxt_tick   = '0;
                    nxt_offset = '0;
                    if (cfg.spread_enable) begin
                        nxt_state = SSM_DOWN;
                    end
                end
                SSM_DOWN: begin
                    // One step per clock: clock is the divider output
                    nxt_offset = offset_ff + ACC_W'(cfg.step);
                    nxt_tick   = expire ? '0 : tick_ff + 1'b1;
                    if (expire) begin
                        nxt_state = SSM_UP;
                    end
                end
                SSM_UP: begin
                    // Floor at zero keeps the value at or below top
                    if (offset_ff > ACC_W'(cfg.step)) begin
                        nxt_offset = offset_ff - ACC_W'(cfg.step);
                    end else begin
                        nxt_offset = '0;
                    end
                    nxt_tick = expire ? '0 : tick_ff + 1'b1;
                    if (expire) begin
                        nxt_state  = SSM_DOWN;
                        nxt_offset = '0;
                    end
                end
                default: nxt_state = SSM_IDLE;
            endcase
            if (!cfg.spread_enable) begin
                nxt_state  = SSM_IDLE;
                nxt_offset = '0;
                nxt_tick   = '0;
            end
        end
    end

    always_comb begin
        // Value below zero cannot occur for legal settings; clamp anyway
        // Back to top the cycle after enable or run drops
        if (state_ff == SSM_IDLE || !cfg.spread_enable ||
            !cfg.divider_run_n) begin
            nxt_div = top;
        end else if (off_div > top) begin
            nxt_div = '0;
        end else begin
            nxt_div = top - off_div;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            state_ff  <= SSM_IDLE;
            tick_ff   <= '0;
            offset_ff <= '0;
            div_ff    <= {RST_DIVIDER_INTEGER, RST_DIVIDER_FRACTION_HIGH,
                          RST_DIVIDER_FRACTION_LOW};
        end else begin
            state_ff  <= nxt_state;
            tick_ff   <= nxt_tick;
            offset_ff <= nxt_offset;
            div_ff    <= nxt_div;
        end
    end

    assign DIV_VALUE = div_ff;
    assign DIV_RESET = ~cfg.divider_run_n;

    // All checks share the one modulator clock
    default clocking cb_ssm @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    sequence s_enabled_run;
        cfg.spread_enable && cfg.divider_run_n;
    endsequence

    // Up ramp away from its turning point
    sequence s_up_step;
        s_enabled_run ##0 (state_ff == SSM_UP && !expire);
    endsequence

    // Last up step, back at the top
    sequence s_up_turn;
        s_enabled_run ##0 (state_ff == SSM_UP && expire);
    endsequence

    a_disabled_top_value: assert property (
        !cfg.spread_enable |=> DIV_VALUE == $past(top))
        else $error("divider value not top while spread off");
    a_never_above_top: assert property (
        $stable(top) |=> DIV_VALUE <= $past(top))
        else $error("divider value above top");
    a_disabled_idle: assert property (
        !cfg.spread_enable |=> state_ff == SSM_IDLE && offset_ff == '0)
        else $error("modulator active while disabled");
    a_reset_holds: assert property (
        !cfg.divider_run_n |-> DIV_RESET ##1 (state_ff == SSM_IDLE))
        else $error("divider not held in reset");
    a_held_top_value: assert property (
        !cfg.divider_run_n |=> DIV_VALUE == $past(top))
        else $error("divider value not top while held");
    a_down_adds_step: assert property (
        s_enabled_run ##0 (state_ff == SSM_DOWN) ##1 cfg.spread_enable
        |-> offset_ff == $past(offset_ff) + ACC_W'($past(cfg.step)))
        else $error("offset not advanced by step");
    a_up_subtracts_step: assert property (
        s_up_step ##0 (offset_ff > ACC_W'(cfg.step))
        |=> offset_ff == $past(offset_ff) - ACC_W'($past(cfg.step)))
        else $error("offset not reduced by step");
    a_reverse_on_expiry: assert property (
        s_enabled_run ##0 (state_ff == SSM_DOWN && expire)
        |=> cfg.spread_enable |-> state_ff == SSM_UP || !cfg.divider_run_n)
        else $error("no reversal at half period");
    a_turn_at_top: assert property (
        s_up_turn |=> state_ff == SSM_DOWN && offset_ff == '0)
        else $error("ramp did not return to top");
    a_tick_advances: assert property (
        s_enabled_run ##0 (state_ff != SSM_IDLE && !expire) ##1 s_enabled_run
        |-> tick_ff == $past(tick_ff) + 1'b1)
        else $error("time step not one per clock");
    a_tick_restarts: assert property (
        s_enabled_run ##0 (state_ff != SSM_IDLE && expire)
        |=> tick_ff == '0)
        else $error("half period count not restarted");
    a_idle_cleared: assert property (
        state_ff == SSM_IDLE |-> offset_ff == '0 && tick_ff == '0)
        else $error("idle state holds stale ramp");
    a_start_from_idle: assert property (
        s_enabled_run ##0 (state_ff == SSM_IDLE) |=> state_ff == SSM_DOWN)
        else $error("modulation did not start");
endmodule
`default_nettype wire

// >>> testbench/ssm_host.sv
// Host software model driving the modulator's byte configuration port
`timescale 1ns/1ps
`default_nettype none
module ssm_host
    import ssm_pkg::*;
(
    // Clock
    input  wire logic       clock,
    // Byte access port
    output logic            wr_en,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        wr_en = 1'b0;
        addr  = 8'h00;
        wdata = 8'h00;
    end
    // Data turns over after release so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        #1 d = rdata;
    endtask
    // Spread off first, so a new top never meets a running ramp
    task automatic setup(input logic [23:0] top, input logic [11:0] hp,
                         input logic [15:0] st);
        wr(OFS_SPREAD_ENABLE_PERIOD_HIGH, {4'h0, hp[11:8]});
        wr(OFS_DIVIDER_INTEGER, top[23:16]);
        wr(OFS_DIVIDER_FRACTION_HIGH, top[15:8]);
        wr(OFS_DIVIDER_FRACTION_LOW, top[7:0]);
        wr(OFS_SPREAD_PERIOD_LOW, hp[7:0]);
        wr(OFS_SPREAD_STEP_HIGH, st[15:8]);
        wr(OFS_SPREAD_STEP_LOW, st[7:0]);
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_ssm_top.sv
// Self-checking bench for the spread-spectrum divider modulator
`timescale 1ns/1ps
`default_nettype none
module test_ssm_top;
    import ssm_pkg::*;
    logic        CLOCK;
    logic        RSTN;
    logic        WR_EN;
    logic [7:0]  ADDR;
    logic [7:0]  WDATA;
    logic [7:0]  RDATA;
    logic [23:0] DIV_VALUE;
    logic        DIV_RESET;
    int          errors;
    int          n_compared;
    logic [7:0]  rst_tab [9] = '{RST_SPREAD_ENABLE_PERIOD_HIGH,
        RST_SPREAD_PERIOD_LOW, RST_DIVIDER_INTEGER, RST_DIVIDER_FRACTION_HIGH,
        RST_DIVIDER_FRACTION_LOW, RST_SPREAD_STEP_HIGH, RST_SPREAD_STEP_LOW,
        8'h00, RST_DIVIDER_CONTROL};
    logic [7:0]  wb [9];
    logic [7:0]  r;
    logic [23:0] top;
    logic [23:0] trough;
    logic [15:0] st;
    int          hp;
    int          he;
    int          over;
    int          k;
    int          m_off;
    int          tq [$];

    ssm_top u_ssm_top (.CLOCK(CLOCK), .RSTN(RSTN), .WR_EN(WR_EN), .ADDR(ADDR),
        .WDATA(WDATA), .RDATA(RDATA), .DIV_VALUE(DIV_VALUE),
        .DIV_RESET(DIV_RESET));
    ssm_host u_ssm_host (.clock(CLOCK), .wr_en(WR_EN), .addr(ADDR),
        .wdata(WDATA), .rdata(RDATA));

    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CLOCK);
        errors++;
        test_done();
    end

    initial begin
        errors = 0;
        n_compared = 0;
        RSTN = 1'b0;
        void'($urandom(32'h52ca));
        repeat (3) @(posedge CLOCK);
        RSTN <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            u_ssm_host.rd(8'h10 + 8'(i), r);
            chk({16'h0, r}, {16'h0, rst_tab[i]});
        end
        chk(DIV_VALUE, 24'h0c8000);
        chk({23'h0, DIV_RESET}, 24'h0);
        $display("Test reset values done");
        // Run bit written low last, so the divider ends up held
        for (int i = 0; i < 9; i++) begin
            wb[i] = 8'($urandom);
            if (i == 8) wb[i][7] = 1'b0;
            u_ssm_host.wr(8'h10 + 8'(i), wb[i]);
            u_ssm_host.rd(8'h10 + 8'(i), r);
            chk({16'h0, r}, {16'h0, (i == 7) ? 8'h00 : (i == 0) ?
                (wb[i] & 8'h8f) : (i == 8) ? 8'h00 : wb[i]});
        end
        repeat (3) @(posedge CLOCK);
        #1 chk({23'h0, DIV_RESET}, 24'h1);
        chk(DIV_VALUE, {wb[2], wb[3], wb[4]});
        u_ssm_host.wr(OFS_DIVIDER_CONTROL, 8'h80);
        #1 chk({23'h0, DIV_RESET}, 24'h0);
        $display("Test register access done");
        for (int i = 0; i < 4; i++) begin
            hp = (i == 0) ? 0 : $urandom_range(1, 20);
            he = (hp == 0) ? 1 : hp;
            st = 16'($urandom_range(256, 65535));
            top = {8'($urandom_range(12, 255)), 16'($urandom)};
            trough = top - 24'((he * st) >> 8);
            u_ssm_host.setup(top, 12'(hp), st);
            repeat (3) @(posedge CLOCK);
            #1 chk(DIV_VALUE, top);
            u_ssm_host.wr(OFS_SPREAD_ENABLE_PERIOD_HIGH, {4'h8, 4'(hp >> 8)});
            repeat (3) @(posedge CLOCK);
            #1 chk(DIV_VALUE, top - 24'(st >> 8));
            tq.delete();
            over = 0;
            for (int c = 3; c < 4 * he + 9; c++) begin
                // Model: he steps down, he steps up, offset in 2^-24 units
                k = c - 3;
                m_off = ((k / he) % 2 == 0) ? (k % he + 1) * int'(st)
                                            : (he - 1 - k % he) * int'(st);
                chk(DIV_VALUE, top - 24'(m_off >> 8));
                if (DIV_VALUE > top) over++;
                if (DIV_VALUE === trough) tq.push_back(c);
                @(posedge CLOCK);
                #1;
            end
            chk(24'(over), 24'h0);
            chk(24'(tq.size() > 0 ? tq[0] : 0), 24'(2 + he));
            chk(24'(tq.size() > 1 ? tq[1] - tq[0] : 0), 24'(2 * he));
            // Switching off mid-ramp must snap back to the top
            u_ssm_host.wr(OFS_SPREAD_ENABLE_PERIOD_HIGH, 8'h00);
            repeat (3) @(posedge CLOCK);
            #1 chk(DIV_VALUE, top);
        end
        $display("Test modulation done");
        test_done();
    end
endmodule
`default_nettype wire
